// ---- hw/amcc_top.sv ----
// amcc_top: operating-mode and clock/channel configuration words, status mirror, ready pin
// assumes: the serial command decoder presents register accesses on the mclk_in domain
`timescale 1ns/1ns
`include "amcc_defs.svh"

// What this block does
// - mode bit 13 enables register-map CRC
// - mode bit 12 enables input frame CRC
// - mode bit 11 picks CCITT or ANSI
// - writing 0 to bit 10 clears reset flag
// - bits 9:8 pick 16 or 24 bits
// - codes 10/11 give padded or sign-extended 32
// - bits 3:2 pick ready pin source
// - idle ready pin high or floating per bit1
// - ready pin low level or fixed pulse
// - clock bit 9 enables channel 1
// - clock bit 8 enables channel 0
// - bits 7:6 divide clock by 2,4,8,12
// - turbo bit forces ratio 64
// - ratio is 128 shifted by code
// - power code 01 low, 10 high resolution
// - clock word at 03h, reset 030Eh
// - mode word at 02h, reset 0510h
// - reset flag set by any reset, sticky
// - status mirrors word length and CRC type
module amcc_top (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire logic reg_wr_in,
    input wire logic reg_rd_in,
    input wire logic [`AMCC_ADDR_W-1:0] reg_addr_in,
    input wire logic [15:0] reg_wdata_in,
    output logic [15:0] reg_rdata_out,
    input wire logic reset_cmd_in,
    input wire logic [1:0] chan_ready_in,
    input wire logic data_read_in,
    input wire logic [23:0] result_in,
    output logic [31:0] word_out,
    output logic [5:0] word_bits_out,
    output logic [15:0] status_out,
    output logic reg_crc_enable_out,
    output logic rx_crc_enable_out,
    output logic crc_ansi_out,
    output logic timeout_enable_out,
    output logic chan1_convert_enable_out,
    output logic chan0_convert_enable_out,
    output logic [3:0] clock_divide_out,
    output logic [14:0] oversampling_ratio_out,
    output logic [1:0] power_profile_out,
    output logic result_ready_pin_out,
    output logic result_ready_pin_oe_n_out
);
    import amcc_pkg::*;

    logic [15:0] mode_q;
    logic [15:0] clock_q;
    logic reset_flag_q;
    logic [1:0] pending_q;
    logic cond_q;
    logic pin_q;
    logic oe_n_q;
    logic [`AMCC_PCNT_W-1:0] pcnt_q;
    amcc_pin_t pin_state_q;
    logic [1:0] chan_en;
    logic [1:0] live;
    logic cond_d;
    logic rise;
    logic wr_mode;
    logic wr_clock;
    amcc_src_t src_sel;
    amcc_wlen_t wlen;

    assign wr_mode = reg_wr_in && (reg_addr_in == `AMCC_ADDR_MODE);
    assign wr_clock = reg_wr_in && (reg_addr_in == `AMCC_ADDR_CLOCK);
    assign src_sel = amcc_src_t'(mode_q[`AMCC_M_SEL_HI:`AMCC_M_SEL_LO]);
    assign wlen = amcc_wlen_t'(mode_q[`AMCC_M_WLEN_HI:`AMCC_M_WLEN_LO]);
    assign chan_en = {clock_q[`AMCC_C_CH1], clock_q[`AMCC_C_CH0]};

    // reserved bits are kept at zero whatever software writes
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            mode_q <= `AMCC_MODE_RESET;
        end else if (wr_mode) begin
            mode_q <= reg_wdata_in & `AMCC_MODE_WMASK;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clock_q <= `AMCC_CLOCK_RESET;
        end else if (wr_clock) begin
            clock_q <= reg_wdata_in & `AMCC_CLOCK_WMASK;
        end
    end

    // a reset command in the same cycle as the clearing write wins
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reset_flag_q <= 1'b1;
        end else if (reset_cmd_in) begin
            reset_flag_q <= 1'b1;
        end else if (wr_mode && !reg_wdata_in[`AMCC_M_RSTF]) begin
            reset_flag_q <= 1'b0;
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_rdata_out <= 16'h0000;
        end else if (reg_rd_in) begin
            unique case (reg_addr_in)
                `AMCC_ADDR_MODE: reg_rdata_out <= mode_q;
                `AMCC_ADDR_CLOCK: reg_rdata_out <= clock_q;
                default: reg_rdata_out <= 16'h0000;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            status_out <= 16'h0000;
        end else begin
            status_out <= {4'h0, mode_q[`AMCC_M_POLY], reset_flag_q,
                mode_q[`AMCC_M_WLEN_HI:`AMCC_M_WLEN_LO], 6'h00, pending_q};
        end
    end

    // decoded settings
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            reg_crc_enable_out <= 1'b0;
            rx_crc_enable_out <= 1'b0;
            crc_ansi_out <= 1'b0;
            timeout_enable_out <= 1'b1;
            chan1_convert_enable_out <= 1'b1;
            chan0_convert_enable_out <= 1'b1;
            power_profile_out <= 2'b10;
        end else begin
            reg_crc_enable_out <= mode_q[`AMCC_M_REGCRC];
            rx_crc_enable_out <= mode_q[`AMCC_M_RXCRC];
            crc_ansi_out <= mode_q[`AMCC_M_POLY];
            timeout_enable_out <= mode_q[`AMCC_M_TMO];
            chan1_convert_enable_out <= chan_en[1];
            chan0_convert_enable_out <= chan_en[0];
            // codes 00 and 11 are passed on untouched; software must not use them
            power_profile_out <= clock_q[`AMCC_C_PWR_HI:`AMCC_C_PWR_LO];
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            clock_divide_out <= 4'h2;
        end else begin
            unique case (clock_q[`AMCC_C_DIV_HI:`AMCC_C_DIV_LO])
                2'b00: clock_divide_out <= 4'h2;
                2'b01: clock_divide_out <= 4'h4;
                2'b10: clock_divide_out <= 4'h8;
                2'b11: clock_divide_out <= 4'hC;
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            oversampling_ratio_out <= 15'h0400;
        end else if (clock_q[`AMCC_C_TURBO]) begin
            oversampling_ratio_out <= `AMCC_OSR_TURBO;
        end else begin
            oversampling_ratio_out <= `AMCC_OSR_BASE << clock_q[`AMCC_C_OSR_HI:`AMCC_C_OSR_LO];
        end
    end

    // per channel pending flag; a new result beats the read that clears it
    for (genvar ch = 0; ch < 2; ch++) begin : g_pend
        always_ff @(posedge mclk_in or negedge resetn_in) begin
            if (!resetn_in) begin
                pending_q[ch] <= 1'b0;
            end else if (chan_ready_in[ch] && chan_en[ch]) begin
                pending_q[ch] <= 1'b1;
            end else if (data_read_in || !chan_en[ch]) begin
                pending_q[ch] <= 1'b0;
            end
        end
    end

    assign live = pending_q & chan_en;

    // lagging waits for every enabled channel, leading takes the first
    always_comb begin
        unique case (src_sel)
            AMCC_SRC_LAG: cond_d = (live == chan_en) && (chan_en != 2'b00);
            AMCC_SRC_OR: cond_d = |live;
            AMCC_SRC_LEAD, AMCC_SRC_LEAD2: cond_d = |live && !cond_q;
        endcase
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            cond_q <= 1'b0;
        end else if (src_sel == AMCC_SRC_LAG || src_sel == AMCC_SRC_OR) begin
            cond_q <= cond_d;
        end else begin
            cond_q <= |live;
        end
    end

    assign rise = (src_sel[1] ? cond_d : cond_d && !cond_q);

    // pin machine: idle level is high or floated, active is low level or fixed pulse
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_state_q <= AMCC_PIN_IDLE;
            pcnt_q <= '0;
        end else begin
            unique case (pin_state_q)
                AMCC_PIN_IDLE: begin
                    if (rise && mode_q[`AMCC_M_PULSE]) begin
                        pin_state_q <= AMCC_PIN_PULSE;
                        pcnt_q <= `AMCC_PCNT_W'(`AMCC_PULSE_CYC - 1);
                    end else if (rise) begin
                        pin_state_q <= AMCC_PIN_LOW;
                    end
                end
                AMCC_PIN_LOW: begin
                    if (!(|live)) begin
                        pin_state_q <= AMCC_PIN_IDLE;
                    end
                end
                AMCC_PIN_PULSE: begin
                    if (pcnt_q == '0) begin
                        pin_state_q <= AMCC_PIN_DONE;
                    end else begin
                        pcnt_q <= pcnt_q - 1'b1;
                    end
                end
                AMCC_PIN_DONE: begin
                    if (!(|live)) begin
                        pin_state_q <= AMCC_PIN_IDLE;
                    end
                end
            endcase
        end
    end

    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            pin_q <= 1'b1;
            oe_n_q <= 1'b0;
        end else if (pin_state_q == AMCC_PIN_LOW || pin_state_q == AMCC_PIN_PULSE) begin
            pin_q <= 1'b0;
            oe_n_q <= 1'b0;
        end else begin
            pin_q <= 1'b1;
            oe_n_q <= mode_q[`AMCC_M_FLOAT];
        end
    end

    assign result_ready_pin_out = pin_q;
    assign result_ready_pin_oe_n_out = oe_n_q;

    amcc_word_fmt u_fmt (
        .mclk_in(mclk_in),
        .resetn_in(resetn_in),
        .word_size_select_in(wlen),
        .result_valid_in(|chan_ready_in),
        .result_in(result_in),
        .word_out(word_out),
        .word_bits_out(word_bits_out)
    );

    sequence s_pulse_low;
        (pin_state_q == AMCC_PIN_PULSE) [*4];
    endsequence

    property p_pulse_len;
        @(posedge mclk_in) disable iff (!resetn_in)
        (pin_state_q == AMCC_PIN_IDLE && rise && mode_q[`AMCC_M_PULSE]) |=> s_pulse_low ##1
            (pin_state_q == AMCC_PIN_DONE);
    endproperty
    a_pulse_len: assert property (p_pulse_len) else $error("ready pulse length wrong");

    property p_idle_float;
        @(posedge mclk_in) disable iff (!resetn_in)
        (pin_state_q == AMCC_PIN_IDLE && mode_q[`AMCC_M_FLOAT]) |=> (oe_n_q && pin_q);
    endproperty
    a_idle_float: assert property (p_idle_float) else $error("idle pin not floated");

    property p_level_low;
        @(posedge mclk_in) disable iff (!resetn_in)
        (pin_state_q == AMCC_PIN_LOW) |=> (!pin_q && !oe_n_q);
    endproperty
    a_level_low: assert property (p_level_low) else $error("ready pin not driven low");

    property p_flag_clear;
        @(posedge mclk_in) disable iff (!resetn_in)
        (wr_mode && !reg_wdata_in[`AMCC_M_RSTF] && !reset_cmd_in) |=> ##1 !status_out[`AMCC_S_RSTF];
    endproperty
    a_flag_clear: assert property (p_flag_clear) else $error("reset flag not cleared");

    property p_flag_set;
        @(posedge mclk_in) disable iff (!resetn_in)
        reset_cmd_in |=> reset_flag_q ##1 status_out[`AMCC_S_RSTF];
    endproperty
    a_flag_set: assert property (p_flag_set) else $error("reset flag not set");

    property p_turbo;
        @(posedge mclk_in) disable iff (!resetn_in)
        (wr_clock && reg_wdata_in[`AMCC_C_TURBO]) |=> ##1 (oversampling_ratio_out == `AMCC_OSR_TURBO);
    endproperty
    a_turbo: assert property (p_turbo) else $error("turbo ratio not 64");

    property p_osr;
        @(posedge mclk_in) disable iff (!resetn_in)
        (wr_clock && !reg_wdata_in[`AMCC_C_TURBO] && reg_wdata_in[4:2] == 3'b111) |=> ##1
            (oversampling_ratio_out == 15'h4000);
    endproperty
    a_osr: assert property (p_osr) else $error("ratio code 7 not 16384");

    property p_div12;
        @(posedge mclk_in) disable iff (!resetn_in)
        (wr_clock && reg_wdata_in[7:6] == 2'b11) |=> ##1 (clock_divide_out == 4'hC);
    endproperty
    a_div12: assert property (p_div12) else $error("divide by 12 wrong");

    property p_mirror;
        @(posedge mclk_in) disable iff (!resetn_in)
        wr_mode |=> ##1 (status_out[9:8] == $past(reg_wdata_in[9:8], 2) &&
            status_out[`AMCC_S_POLY] == $past(reg_wdata_in[11], 2));
    endproperty
    a_mirror: assert property (p_mirror) else $error("status mirror wrong");

    property p_crc_en;
        @(posedge mclk_in) disable iff (!resetn_in)
        wr_mode |=> ##1 (reg_crc_enable_out == $past(reg_wdata_in[13], 2) &&
            rx_crc_enable_out == $past(reg_wdata_in[12], 2));
    endproperty
    a_crc_en: assert property (p_crc_en) else $error("crc enables wrong");
endmodule : amcc_top

// ---- hw/amcc_defs.svh ----
// amcc_defs.svh: register offsets, field positions, reset values and timing counts
// assumes: included by the package and by the modules of the configuration block
`ifndef AMCC_DEFS_SVH
`define AMCC_DEFS_SVH

`define AMCC_ADDR_W 6
`define AMCC_ADDR_MODE 6'h02
`define AMCC_ADDR_CLOCK 6'h03

`define AMCC_MODE_RESET 16'h0510
`define AMCC_CLOCK_RESET 16'h030E
`define AMCC_MODE_WMASK 16'h3F1F
`define AMCC_CLOCK_WMASK 16'h03FF

// operating-mode word fields
`define AMCC_M_REGCRC 13
`define AMCC_M_RXCRC 12
`define AMCC_M_POLY 11
`define AMCC_M_RSTF 10
`define AMCC_M_WLEN_HI 9
`define AMCC_M_WLEN_LO 8
`define AMCC_M_TMO 4
`define AMCC_M_SEL_HI 3
`define AMCC_M_SEL_LO 2
`define AMCC_M_FLOAT 1
`define AMCC_M_PULSE 0

// clock word fields
`define AMCC_C_CH1 9
`define AMCC_C_CH0 8
`define AMCC_C_DIV_HI 7
`define AMCC_C_DIV_LO 6
`define AMCC_C_TURBO 5
`define AMCC_C_OSR_HI 4
`define AMCC_C_OSR_LO 2
`define AMCC_C_PWR_HI 1
`define AMCC_C_PWR_LO 0

// status word positions
`define AMCC_S_POLY 11
`define AMCC_S_RSTF 10

`define AMCC_OSR_BASE 15'h0080
`define AMCC_OSR_TURBO 15'h0040

// fixed low pulse on the ready pin
`define AMCC_PULSE_NS 32
`define AMCC_CLK_NS 8
`define AMCC_PULSE_CYC ((`AMCC_PULSE_NS + `AMCC_CLK_NS - 1) / `AMCC_CLK_NS)
`define AMCC_PCNT_W 4

`endif

// ---- hw/amcc_pkg.sv ----
// amcc_pkg: types shared by the configuration block
// assumes: amcc_defs.svh is on the include path
`include "amcc_defs.svh"
package amcc_pkg;
    typedef enum logic [1:0] {
        AMCC_WL_16 = 2'b00,
        AMCC_WL_24 = 2'b01,
        AMCC_WL_32Z = 2'b10,
        AMCC_WL_32S = 2'b11
    } amcc_wlen_t;

    typedef enum logic [1:0] {
        AMCC_SRC_LAG = 2'b00,
        AMCC_SRC_OR = 2'b01,
        AMCC_SRC_LEAD = 2'b10,
        AMCC_SRC_LEAD2 = 2'b11
    } amcc_src_t;

    typedef enum {
        AMCC_PIN_IDLE,
        AMCC_PIN_LOW,
        AMCC_PIN_PULSE,
        AMCC_PIN_DONE
    } amcc_pin_t;
endpackage : amcc_pkg

// ---- hw/amcc_word_fmt.sv ----
// amcc_word_fmt: shapes a 24-bit conversion result into the selected frame word
// assumes: result and strobe come from the datapath on the same clock
`timescale 1ns/1ns
module amcc_word_fmt (
    input wire logic mclk_in,
    input wire logic resetn_in,
    input wire amcc_pkg::amcc_wlen_t word_size_select_in,
    input wire logic result_valid_in,
    input wire logic [23:0] result_in,
    output logic [31:0] word_out,
    output logic [5:0] word_bits_out
);
    import amcc_pkg::*;

    // result is left justified except in sign-extended 32-bit mode, where it sits in bits 23:0; first bit sent is bit 31
    always_ff @(posedge mclk_in or negedge resetn_in) begin
        if (!resetn_in) begin
            word_out <= 32'h0000_0000;
            word_bits_out <= 6'h18;
        end else if (result_valid_in) begin
            unique case (word_size_select_in)
                AMCC_WL_16: begin
                    word_out <= {result_in[23:8], 16'h0000};
                    word_bits_out <= 6'h10;
                end
                AMCC_WL_24: begin
                    word_out <= {result_in, 8'h00};
                    word_bits_out <= 6'h18;
                end
                AMCC_WL_32Z: begin
                    word_out <= {result_in, 8'h00};
                    word_bits_out <= 6'h20;
                end
                AMCC_WL_32S: begin
                    word_out <= {{8{result_in[23]}}, result_in};
                    word_bits_out <= 6'h20;
                end
            endcase
        end
    end

    property p_sign_ext;
        @(posedge mclk_in) disable iff (!resetn_in)
        (result_valid_in && word_size_select_in == AMCC_WL_32S) |=>
            (word_out[31:24] == {8{$past(result_in[23])}} && word_bits_out == 6'h20);
    endproperty
    a_sign_ext: assert property (p_sign_ext) else $error("sign extension word wrong");

    property p_zero_pad;
        @(posedge mclk_in) disable iff (!resetn_in)
        (result_valid_in && word_size_select_in == AMCC_WL_32Z) |=>
            (word_out == {$past(result_in), 8'h00});
    endproperty
    a_zero_pad: assert property (p_zero_pad) else $error("zero padded word wrong");

    property p_len16;
        @(posedge mclk_in) disable iff (!resetn_in)
        (result_valid_in && word_size_select_in == AMCC_WL_16) |=> (word_bits_out == 6'h10);
    endproperty
    a_len16: assert property (p_len16) else $error("16-bit length wrong");
endmodule : amcc_word_fmt

// ---- testbench/amcc_host_model.sv ----
// amcc_host_model: host side of the register path, one access per task call
// assumes: tb calls the tasks; signals change at the falling edge of mclk_in
`timescale 1ns/1ns
module amcc_host_model (
    input wire logic mclk_in,
    output logic reg_wr_out,
    output logic reg_rd_out,
    output logic [5:0] reg_addr_out,
    output logic [15:0] reg_wdata_out,
    input wire logic [15:0] reg_rdata_in
);
    initial begin
        reg_wr_out = 1'b0;
        reg_rd_out = 1'b0;
        reg_addr_out = 6'h00;
        reg_wdata_out = 16'h0000;
    end

    // a real host never sends reserved ones or the two unused power codes
    function automatic logic [15:0] clean(input logic [5:0] a, input logic [15:0] d);
        if (a == 6'h02) begin
            return d & 16'h3F1F;
        end
        if (a == 6'h03) begin
            if (d[1:0] == 2'b00 || d[1:0] == 2'b11) begin
                d[1:0] = 2'b10;
            end
            return d & 16'h03FF;
        end
        return d;
    endfunction : clean

    task automatic write_reg(input logic [5:0] a, input logic [15:0] d);
        @(negedge mclk_in);
        reg_wr_out = 1'b1;
        reg_addr_out = a;
        reg_wdata_out = clean(a, d);
        @(negedge mclk_in);
        reg_wr_out = 1'b0;
        // stale data is inverted so nothing relies on it
        reg_wdata_out = ~reg_wdata_out;
    endtask : write_reg

    task automatic read_reg(input logic [5:0] a, output logic [15:0] d);
        @(negedge mclk_in);
        reg_rd_out = 1'b1;
        reg_addr_out = a;
        @(negedge mclk_in);
        reg_rd_out = 1'b0;
        reg_addr_out = ~a;
        @(negedge mclk_in);
        d = reg_rdata_in;
    endtask : read_reg
endmodule : amcc_host_model

// ---- testbench/tb.sv ----
// tb: self-checking bench for the configuration block
// assumes: amcc_host_model drives the register path, the rest is driven here
`timescale 1ns/1ns
module tb;
    import amcc_pkg::*;
    logic mclk_in = 1'b0;
    logic resetn_in = 1'b0;
    logic reg_wr, reg_rd, reset_cmd_in = 1'b0, data_read_in = 1'b0;
    logic [5:0] reg_addr;
    logic [15:0] reg_wdata, reg_rdata, status_out, v;
    logic [1:0] chan_ready_in = 2'b00, power_profile_out;
    logic [23:0] result_in = 24'h00_0000;
    logic [31:0] word_out;
    logic [5:0] word_bits_out;
    logic reg_crc, rx_crc, crc_ansi, tmo_en, chan1_convert_enable, chan0_convert_enable, pin, pin_oe_n;
    logic [3:0] clock_divide_out;
    logic [14:0] osr_out;
    int err_count = 0, cmp_count = 0, cycles = 0, i, j, lows;
    logic [15:0] pin_mode [7] = '{16'h0410, 16'h0410, 16'h0414, 16'h0415, 16'h0418, 16'h041C, 16'h0414};
    logic [15:0] pin_clk [7] = '{16'h030E, 16'h030E, 16'h030E, 16'h030E, 16'h030E, 16'h030E, 16'h020E};
    logic [1:0] pin_rdy [7] = '{2'b01, 2'b10, 2'b10, 2'b01, 2'b01, 2'b10, 2'b01};
    int pin_lows [7] = '{0, 10, 10, 4, 10, 10, 0};

    always #4 mclk_in = ~mclk_in;

    amcc_host_model u_host (.mclk_in(mclk_in), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
        .reg_addr_out(reg_addr), .reg_wdata_out(reg_wdata), .reg_rdata_in(reg_rdata));

    amcc_top u_dut (.mclk_in(mclk_in), .resetn_in(resetn_in), .reg_wr_in(reg_wr), .reg_rd_in(reg_rd),
        .reg_addr_in(reg_addr), .reg_wdata_in(reg_wdata), .reg_rdata_out(reg_rdata),
        .reset_cmd_in(reset_cmd_in), .chan_ready_in(chan_ready_in), .data_read_in(data_read_in),
        .result_in(result_in), .word_out(word_out), .word_bits_out(word_bits_out),
        .status_out(status_out), .reg_crc_enable_out(reg_crc), .rx_crc_enable_out(rx_crc),
        .crc_ansi_out(crc_ansi), .timeout_enable_out(tmo_en), .chan1_convert_enable_out(chan1_convert_enable),
        .chan0_convert_enable_out(chan0_convert_enable), .clock_divide_out(clock_divide_out),
        .oversampling_ratio_out(osr_out), .power_profile_out(power_profile_out),
        .result_ready_pin_out(pin), .result_ready_pin_oe_n_out(pin_oe_n));

    task automatic results();
        $display("comparisons %0d mismatches %0d", cmp_count, err_count);
        if (err_count == 0 && cmp_count > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : results

    // ceiling is about fifty times the length of the planned sequence
    always @(posedge mclk_in) begin
        cycles++;
        if (cycles == 20000) begin
            err_count++;
            results();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk

    task automatic wait_n(input int n);
        repeat (n) @(negedge mclk_in);
    endtask : wait_n

    task automatic rd_chk(input logic [5:0] a, input logic [15:0] e);
        logic [15:0] d;
        u_host.read_reg(a, d);
        chk(32'(d), 32'(e));
    endtask : rd_chk

    function automatic logic [3:0] exp_div(input logic [1:0] c);
        return (c == 2'b11) ? 4'hC : 4'h2 << c;
    endfunction : exp_div

    function automatic logic [14:0] exp_osr(input logic t, input logic [2:0] c);
        return t ? 15'h0040 : 15'h0080 << c;
    endfunction : exp_osr

    function automatic logic [31:0] exp_word(input logic [1:0] wl, input logic [23:0] r);
        case (wl)
            2'b00: return {r[23:8], 16'h0000};
            2'b11: return {{8{r[23]}}, r};
            default: return {r, 8'h00};
        endcase
    endfunction : exp_word

    initial begin
        void'($urandom(32'h85e0));
        wait_n(4);
        resetn_in = 1'b1;
        wait_n(1);
        chk(32'(status_out[10]), 32'h0000_0001);
        chk(32'({clock_divide_out, 1'b0, osr_out}), 32'({4'h2, 1'b0, 15'h0400}));
        chk(32'({power_profile_out, chan1_convert_enable, chan0_convert_enable}), 32'h0000_000B);
        chk(32'({pin, pin_oe_n}), 32'h0000_0002);
        rd_chk(6'h02, 16'h0510);
        rd_chk(6'h03, 16'h030E);
        rd_chk(6'h05, 16'h0000);
        // clock word: corners first, then random fields
        for (i = 0; i < 12; i++) begin
            v = (i == 0) ? 16'h0001 : (i == 1) ? 16'h03FD : (i == 2) ? 16'h009E : 16'($urandom) & 16'h03FF;
            if (v[1:0] == 2'b00 || v[1:0] == 2'b11) begin
                v[1:0] = 2'b01;
            end
            u_host.write_reg(6'h03, v);
            wait_n(2);
            chk(32'({chan1_convert_enable, chan0_convert_enable}), 32'(v[9:8]));
            chk(32'(clock_divide_out), 32'(exp_div(v[7:6])));
            chk(32'(osr_out), 32'(exp_osr(v[5], v[4:2])));
            chk(32'(power_profile_out), 32'(v[1:0]));
            rd_chk(6'h03, v);
        end
        // mode word: crc, timeout and status mirror
        for (i = 0; i < 10; i++) begin
            v = ((i == 0) ? 16'h3F1F : (i == 1) ? 16'h0400 : 16'($urandom) & 16'h3F1F) | 16'h0400;
            u_host.write_reg(6'h02, v);
            wait_n(2);
            chk(32'({reg_crc, rx_crc, crc_ansi, tmo_en}), 32'({v[13:11], v[4]}));
            chk(32'({status_out[11], status_out[9:8]}), 32'({v[11], v[9:8]}));
            rd_chk(6'h02, v);
        end
        // reset flag cleared by a zero, set again by the reset command
        u_host.write_reg(6'h02, 16'h0110);
        wait_n(2);
        chk(32'(status_out[10]), 32'h0000_0000);
        reset_cmd_in = 1'b1;
        wait_n(1);
        reset_cmd_in = 1'b0;
        wait_n(2);
        chk(32'(status_out[10]), 32'h0000_0001);
        // every word length with a random result
        u_host.write_reg(6'h03, 16'h030E);
        for (i = 0; i < 8; i++) begin
            u_host.write_reg(6'h02, {6'h00, 2'(i), 8'h10});
            wait_n(2);
            result_in = (i == 3) ? 24'h80_00F1 : 24'($urandom);
            chan_ready_in = 2'b11;
            wait_n(1);
            chan_ready_in = 2'b00;
            wait_n(1);
            chk(word_out, exp_word(2'(i), result_in));
            chk(32'(word_bits_out), (i % 4 == 0) ? 32'h10 : (i % 4 == 1) ? 32'h18 : 32'h20);
            data_read_in = 1'b1;
            wait_n(1);
            data_read_in = 1'b0;
        end
        // ready pin: source select, level and pulse, disabled channel
        for (i = 0; i < 7; i++) begin
            u_host.write_reg(6'h02, pin_mode[i]);
            u_host.write_reg(6'h03, pin_clk[i]);
            wait_n(2);
            result_in = 24'($urandom);
            chan_ready_in = pin_rdy[i];
            lows = 0;
            for (j = 0; j < 12; j++) begin
                @(negedge mclk_in);
                chan_ready_in = 2'b00;
                lows += (pin === 1'b0);
            end
            chk(32'(lows), 32'(pin_lows[i]));
            if (i != 0) begin
                data_read_in = 1'b1;
                wait_n(1);
                data_read_in = 1'b0;
                wait_n(4);
                chk(32'({pin, pin_oe_n}), 32'h0000_0002);
            end
        end
        u_host.write_reg(6'h02, 16'h0416);
        wait_n(2);
        chk(32'(pin_oe_n), 32'h0000_0001);
        // second reset in mid-run restores defaults
        resetn_in = 1'b0;
        wait_n(2);
        resetn_in = 1'b1;
        wait_n(1);
        chk(32'(status_out[10]), 32'h0000_0001);
        rd_chk(6'h03, 16'h030E);
        rd_chk(6'h02, 16'h0510);
        results();
    end
endmodule : tb
